// [pcv_top.sv]
/*
 * Pulse count voltage select: wire filter, pulse counter, enable/wire mode logic and discharge.
 * Assumes all pins synchronous to sys_clk and an analog comparator reporting outputs at 0 V.
 */
`timescale 1ns/1ps
`include "pcv_consts.svh"
module pcv_top #(
	parameter int FILT_CYC = `PCV_FILT_CYC,
	parameter int IDLE_CYC = `PCV_IDLE_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic enable,
	input wire logic prog_wire,
	input wire logic discharge_select,
	input wire logic outputs_at_zero,
	output pcv_pkg::pcv_code_t negative_rail,
	output logic converter_on,
	output logic power_switch_closed,
	output logic discharge_switch_closed
);
	import pcv_pkg::*;

	logic wire_filt;
	logic next_wire_filt;
	logic [15:0] filt_cnt;
	logic [15:0] next_filt_cnt;
	logic filt_done;
	logic wire_filt_d;
	logic wire_fall;
	logic [15:0] idle_cnt;
	logic [15:0] next_idle_cnt;
	logic idle_done;
	logic [5:0] pulse_cnt;
	logic [5:0] next_pulse_cnt;
	pcv_code_t prog_code;
	pcv_code_t next_prog_code;
	pcv_state_e state;
	pcv_state_e next_state;
	logic run_req;
	pcv_code_t next_rail;
	logic next_discharge;

	// A level must persist FILT_CYC cycles before it is accepted, on both edges.
	assign filt_done = (filt_cnt >= 16'(FILT_CYC - 1)); // RL12

	always_comb begin
		next_wire_filt = wire_filt;
		next_filt_cnt = filt_cnt;
		if (prog_wire == wire_filt) begin
			next_filt_cnt = 16'h0000; // RL12
		end else if (filt_done) begin
			next_wire_filt = prog_wire; // RL12
			next_filt_cnt = 16'h0000;
		end else begin
			next_filt_cnt = filt_cnt + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wire_filt <= 1'b0;
		end else begin
			wire_filt <= next_wire_filt;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			filt_cnt <= 16'h0000;
		end else begin
			filt_cnt <= next_filt_cnt;
		end
	end

	// The delayed copy resets low, so the idle-high wire after reset gives no false fall.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wire_filt_d <= 1'b0;
		end else begin
			wire_filt_d <= wire_filt;
		end
	end

	// Only the filtered level is edge-detected, so a glitch can never add a pulse.
	assign wire_fall = wire_filt_d && !wire_filt; // RL14
	// Idle time runs only while a train is pending, so a quiet wire latches nothing.
	assign idle_done = (idle_cnt >= 16'(IDLE_CYC - 1)); // RL14

	// Counts saturate at the top code so an overlong train stays at the top level.
	always_comb begin
		next_pulse_cnt = pulse_cnt;
		next_idle_cnt = idle_cnt;
		next_prog_code = prog_code;
		if (!wire_filt) begin
			next_idle_cnt = 16'h0000;
			if (wire_fall && pulse_cnt < `PCV_CODE_MAX) begin
				next_pulse_cnt = pulse_cnt + 6'h01; // RL14
			end
		end else if (pulse_cnt != `PCV_CODE_OFF) begin
			if (idle_done) begin
				next_prog_code = pulse_cnt; // RL1 RL14
				next_pulse_cnt = `PCV_CODE_OFF;
				next_idle_cnt = 16'h0000;
			end else begin
				next_idle_cnt = idle_cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pulse_cnt <= `PCV_CODE_OFF;
		end else begin
			pulse_cnt <= next_pulse_cnt;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			idle_cnt <= 16'h0000;
		end else begin
			idle_cnt <= next_idle_cnt;
		end
	end

	// The stored code survives the off state; only rst_b brings back the default.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			prog_code <= `PCV_CODE_DEF;
		end else begin
			prog_code <= next_prog_code;
		end
	end

	// Either pin keeps the converter running; the wire alone runs it at the programmed code.
	assign run_req = enable || wire_filt; // RL3 RL4 RL9

	// Discharge is entered only from run, so a cold start never closes the switches.
	always_comb begin
		next_state = state;
		case (state)
			PCV_OFF: begin
				if (run_req) begin
					next_state = PCV_RUN;
				end
			end
			PCV_RUN: begin
				if (!run_req) begin
					// Discharge choice comes from discharge_select alone.
					next_state = discharge_select ? PCV_OFF : PCV_DISCHARGE; // RL6 RL7 RL8
				end
			end
			PCV_DISCHARGE: begin
				if (run_req) begin
					next_state = PCV_RUN;
				end else if (outputs_at_zero) begin
					next_state = PCV_OFF; // RL13
				end
			end
			default: next_state = PCV_OFF;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= PCV_OFF;
		end else begin
			state <= next_state;
		end
	end

	// Enable wins over the wire, so the programmed code shows only with enable low.
	always_comb begin
		if (enable) begin
			next_rail = `PCV_CODE_DEF; // RL2
		end else if (wire_filt) begin
			next_rail = prog_code; // RL4
		end else begin
			next_rail = `PCV_CODE_OFF; // RL3
		end
	end

	// The switch opens on the next sys_clk edge after discharge_select rises, even mid-discharge.
	always_comb begin
		next_discharge = !run_req && !discharge_select && !outputs_at_zero
			&& (state != PCV_OFF); // RL6 RL7 RL13
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			negative_rail <= `PCV_CODE_OFF;
		end else begin
			negative_rail <= next_rail;
		end
	end

	// The converter and power switch follow the run request, so the power switch is open whenever the device is off.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			converter_on <= 1'b0;
		end else begin
			converter_on <= run_req; // RL9
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			power_switch_closed <= 1'b0;
		end else begin
			power_switch_closed <= run_req; // RL10
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			discharge_switch_closed <= 1'b0;
		end else begin
			discharge_switch_closed <= next_discharge;
		end
	end
endmodule : pcv_top

// [pcv_consts.svh]
/*
 * Constants for the pulse count voltage select block: rail codes, filter and idle timing.
 * Assumes a single 100 MHz clock and synchronous pin inputs.
 */
// Notes on behaviour
// [RL1] Pulse count k of 1..41 selects level -6.4 V plus (k-1) times 100 mV.
// [RL2] Enable high forces the default level, code for 16 pulses, -4.9 V.
// [RL3] Enable low and wire low turns the device fully off.
// [RL4] Enable low and wire high runs at the level the pulse count selected.
// [RL5] Host keeps enable at analog ground while programming over the wire.
// [RL6] Discharge select low discharges outputs actively after shutdown.
// [RL7] Discharge select high means no fast output discharge at all.
// [RL8] Only discharge select decides discharge; enable never changes that choice.
// [RL9] Runs while enable high; enable falling stops switching and turns blocks off. The code keeps running while wire_filt is high.
// [RL10] When off all internal power switches stay open.
// [RL11] Host pulses no faster than 250 kHz.
// [RL12] Wire input filtered on both edges so glitches never count.
// [RL13] Discharge switches close until outputs reach 0 V, then open.
// [RL14] Low-going pulses counted, count latched after idle time with wire high.
`ifndef PCV_CONSTS_SVH
`define PCV_CONSTS_SVH
`define PCV_CLK_MHZ 100
`define PCV_FILT_NS 500
`define PCV_FILT_CYC ((`PCV_FILT_NS * `PCV_CLK_MHZ) / 1000)
`define PCV_IDLE_US 80
`define PCV_IDLE_CYC (`PCV_IDLE_US * `PCV_CLK_MHZ)
`define PCV_CODE_MIN 6'h01
`define PCV_CODE_MAX 6'h29
`define PCV_CODE_DEF 6'h10
`define PCV_CODE_OFF 6'h00
`endif

// [pcv_pkg.sv]
/*
 * Types shared by the pulse count voltage select block.
 * Assumes nothing of its surroundings.
 */
package pcv_pkg;
	typedef enum logic [1:0] {
		PCV_OFF = 2'b00,
		PCV_RUN = 2'b01,
		PCV_DISCHARGE = 2'b10
	} pcv_state_e;
	typedef logic [5:0] pcv_code_t;
endpackage : pcv_pkg

// [pcv_host.sv]
/* Host model on the wire. Assumes short filter and idle counts. */
`timescale 1ns/1ps
module pcv_host (
	input logic sys_clk,
	output logic prog_wire = 1'b1
);
	task automatic send(input int k, input int lo);
		repeat (k) begin
			prog_wire = 1'b0;
			repeat (lo) @(negedge sys_clk);
			prog_wire = 1'b1;
			repeat (4) @(negedge sys_clk);
		end
		repeat (30) @(negedge sys_clk);
	endtask : send
endmodule : pcv_host

// [pcv_checker.sv]
/* Port checker for pcv_top. Assumes a two cycle wire filter. */
`timescale 1ns/1ps
module pcv_checker (
	input logic sys_clk,
	input logic rst_b,
	input logic enable,
	input logic prog_wire,
	input logic discharge_select,
	input logic outputs_at_zero,
	input pcv_pkg::pcv_code_t negative_rail,
	input logic converter_on,
	input logic power_switch_closed,
	input logic discharge_switch_closed
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	a_def_code: assert property (enable [*3] |-> negative_rail == 6'h10) else $error("def");
	a_rail_max: assert property (negative_rail <= 6'h29) else $error("max");
	a_off_zero: assert property (!converter_on |-> negative_rail == 6'h00) else $error("off");
	a_sw_open: assert property (power_switch_closed == converter_on) else $error("sw");
	a_no_fast: assert property (discharge_select |=> !discharge_switch_closed)
		else $error("fd");
	a_zero_stop: assert property (discharge_switch_closed && outputs_at_zero
		|=> !discharge_switch_closed) else $error("stop");
	a_dis_off: assert property (discharge_switch_closed |-> !converter_on) else $error("on");
	a_wire_filt: assert property ($rose(converter_on) && !enable
		|-> $past(prog_wire) && $past(prog_wire, 2)) else $error("filt");
	c_fd: cover property (discharge_switch_closed);
	c_top: cover property (negative_rail == 6'h29);
	c_en: cover property (enable && converter_on);
endmodule : pcv_checker
bind pcv_top pcv_checker chk (.*);

// [tb_pcv_top.sv]
/* Bench for pcv_top. Assumes pcv_host drives the wire. */
`timescale 1ns/1ps
module tb_pcv_top;
	logic sys_clk = 1'b0, rst_b = 1'b0, enable = 1'b0;
	logic discharge_select = 1'b0, outputs_at_zero = 1'b0;
	logic prog_wire, converter_on, power_switch_closed, discharge_switch_closed;
	pcv_pkg::pcv_code_t negative_rail;
	int n_mismatch = 0, checked = 0;
	always #5 sys_clk = ~sys_clk;
	pcv_host host (.*);
	pcv_top #(.FILT_CYC(2), .IDLE_CYC(20)) dut (.*);
	task automatic chk(input logic [5:0] got, input logic [5:0] exp);
		checked++;
		if (got !== exp) n_mismatch++;
		if (got !== exp) $display("unexpected %0t %h", $time, got);
	endtask : chk
	task automatic close_out();
		$display("fail %0d of %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : close_out
	task automatic t_codes();
		host.send(1, 4);
		chk(negative_rail, 6'h01);
		chk(converter_on, 1'b1);
		chk(power_switch_closed, 1'b1);
		host.send(45, 4);
		chk(negative_rail, 6'h29);
		host.send(1, 1);
		chk(negative_rail, 6'h29);
	endtask : t_codes
	task automatic t_off();
		enable = 1'b1;
		host.prog_wire = 1'b0;
		repeat (9) @(negedge sys_clk);
		chk(negative_rail, 6'h10);
		enable = 1'b0;
		repeat (9) @(negedge sys_clk);
		chk(discharge_switch_closed, 1'b1);
		chk(converter_on, 1'b0);
		chk(power_switch_closed, 1'b0);
		chk(negative_rail, 6'h00);
		outputs_at_zero = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk(discharge_switch_closed, 1'b0);
		{outputs_at_zero, discharge_select} = 2'h1;
		host.send(2, 4);
		host.prog_wire = 1'b0;
		repeat (9) @(negedge sys_clk);
		chk(discharge_switch_closed, 1'b0);
	endtask : t_off
	initial begin
		repeat (20) @(negedge sys_clk);
		rst_b = 1'b1;
		repeat (8) @(negedge sys_clk);
		t_codes();
		t_off();
		close_out();
	end
endmodule : tb_pcv_top
